// File: logic/sram_defs.svh
// Constants for the two-word burst SRAM port
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH

// Variant widths of the shared data bus and its lane selects
`define SRAM_DQ_W 36
`define SRAM_NIBBLE_DQ_W 8
`define SRAM_NIBBLE_W 4
`define SRAM_NIBBLE_SEL_W 2
`define SRAM_LANE_W 9
`define SRAM_BYTE_SEL_MAX 4

// Address width per array (kept small for simulation)
`define SRAM_ADDR_W 10

// Read latency in positive-clock cycles, normal and DLL-off timing
`define SRAM_RD_LAT 2
`define SRAM_DLL_OFF_RD_LAT 1

// Number of access event kinds crossing to the core clock
`define SRAM_EVT_W 2

`endif

// File: logic/sram_port_pkg.sv
// Types shared by the two-word burst SRAM port
`default_nettype none
package sram_port_pkg;

    // Output timing selected by the DLL strap
    typedef enum logic {
        MODE_DLL_ON,
        MODE_DLL_OFF
    } timing_mode_t;

    // One toggle per access kind, crossing to the core clock
    typedef struct packed {
        logic wr;
        logic rd;
    } acc_evt_t;

endpackage
`default_nettype wire

// File: logic/pin_sync3.sv
// Three-stage synchroniser with agreement filter
`default_nettype none
module pin_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // First stage feeds the second only; change counts once 2 and 3 agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            level <= RESET_VAL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level <= s3_q;
            end
        end
    end

endmodule
`default_nettype wire

// File: logic/burst_storage.sv
// Two word arrays, one per burst beat, with lane-masked writes
`default_nettype none
`include "sram_defs.svh"
module burst_storage #(
    parameter int DATA_W = `SRAM_DQ_W,
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int LANE_W = `SRAM_LANE_W,
    parameter int SEL_W = 4
) (
    input wire logic k_clk,
    input wire logic kn_clk,
    input wire logic rst_n,
    input wire logic we0,
    input wire logic we1,
    input wire logic [ADDR_W-1:0] waddr0,
    input wire logic [ADDR_W-1:0] waddr1,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [SEL_W-1:0] wsel_n,
    input wire logic [ADDR_W-1:0] raddr0,
    input wire logic [ADDR_W-1:0] raddr1,
    output logic [DATA_W-1:0] rdata0,
    output logic [DATA_W-1:0] rdata1
);

    localparam int DEPTH = 1 << ADDR_W;

    logic [DATA_W-1:0] even_q [DEPTH];
    logic [DATA_W-1:0] odd_q [DEPTH];
    wire logic [DATA_W-1:0] old0 = even_q[waddr0];
    wire logic [DATA_W-1:0] old1 = odd_q[waddr1];
    logic [DATA_W-1:0] merged0;
    logic [DATA_W-1:0] merged1;

    // Unselected lanes keep the stored value (read-merge-write)
    for (genvar l = 0; l < SEL_W; l++) begin : g_lane
        assign merged0[l*LANE_W +: LANE_W] = wsel_n[l] ?
            old0[l*LANE_W +: LANE_W] :
            wdata[l*LANE_W +: LANE_W];
        assign merged1[l*LANE_W +: LANE_W] = wsel_n[l] ?
            old1[l*LANE_W +: LANE_W] :
            wdata[l*LANE_W +: LANE_W];
    end

    ////////////////////////////////////////////////////////////////////
    // First beat lands in the even array on the positive clock
    always_ff @(posedge k_clk) begin
        if (we0) begin
            even_q[waddr0] <= merged0;
        end
    end

    // Second beat lands in the odd array on the negative clock
    always_ff @(posedge kn_clk) begin
        if (we1) begin
            odd_q[waddr1] <= merged1;
        end
    end

    // Asynchronous read; the caller registers the result
    assign rdata0 = even_q[raddr0];
    assign rdata1 = odd_q[raddr1];

    ////////////////////////////////////////////////////////////////////
    a_even_mask_hold: assert property (
        @(posedge k_clk) disable iff (!rst_n)
        (we0 && (&wsel_n)) |=> even_q[$past(waddr0)] == $past(old0))
    else $error("masked first beat changed the stored word");

    a_odd_mask_hold: assert property (
        @(posedge kn_clk) disable iff (!rst_n)
        (we1 && (&wsel_n)) |=> odd_q[$past(waddr1)] == $past(old1))
    else $error("masked second beat changed the stored word");

endmodule
`default_nettype wire

// File: logic/ddr_burst2_sram_port.sv
// Device side of a two-word burst double-data-rate SRAM port
`default_nettype none
`include "sram_defs.svh"
module ddr_burst2_sram_port
    import sram_port_pkg::*;
#(
    parameter int DATA_W = `SRAM_DQ_W,
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int RD_LAT = `SRAM_RD_LAT,
    parameter int DLL_OFF_RD_LAT = `SRAM_DLL_OFF_RD_LAT,
    parameter int BYTE_SEL_W = `SRAM_BYTE_SEL_MAX
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic k_clk,
    input wire logic kn_clk,
    input wire logic load_strobe_n,
    input wire logic rw_dir,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe,
    input wire logic [`SRAM_NIBBLE_SEL_W-1:0] nibble_write_sel_n,
    input wire logic [BYTE_SEL_W-1:0] byte_lane_write_sel_n,
    input wire logic dll_disable_n,
    output logic output_valid_flag,
    output logic echo_timing_out,
    output logic echo_timing_out_n,
    output logic rd_event,
    output logic wr_event,
    output logic dll_off_status
);

    localparam bit NIBBLE_MODE = (DATA_W == `SRAM_NIBBLE_DQ_W);
    localparam int LANE_W = NIBBLE_MODE ? `SRAM_NIBBLE_W : `SRAM_LANE_W;
    localparam int SEL_W = DATA_W / LANE_W;
    localparam int RD_LAT_A = RD_LAT;
    localparam int DLL_LAT_A = DLL_OFF_RD_LAT;

    ////////////////////////////////////////////////////////////////////
    // Link reset: asserts at once, releases on the positive clock
    logic krst_meta_q;
    logic krst_sync_q;
    wire logic k_rst_n = krst_sync_q;

    always_ff @(posedge k_clk or negedge rstn) begin
        if (!rstn) begin
            krst_meta_q <= 1'b0;
            krst_sync_q <= 1'b0;
        end else begin
            krst_meta_q <= 1'b1;
            krst_sync_q <= krst_meta_q;
        end
    end

    // Strap is asynchronous to the link, so it is filtered first
    logic dll_on_k;
    pin_sync3 #(.RESET_VAL(1'b1)) u_dll_k (
        .clk(k_clk),
        .rst_n(k_rst_n),
        .pin(dll_disable_n),
        .level(dll_on_k)
    );
    wire timing_mode_t mode = dll_on_k ? MODE_DLL_ON : MODE_DLL_OFF;
    wire logic dll_off = (mode == MODE_DLL_OFF);

    ////////////////////////////////////////////////////////////////////
    // Command decode, valid only at a positive clock edge
    wire logic cmd_ld = !load_strobe_n;
    wire logic cmd_rd = cmd_ld && rw_dir;
    wire logic cmd_wr = cmd_ld && !rw_dir;

    // Lane selects come from the pins that the variant has
    logic [SEL_W-1:0] sel_n;
    if (NIBBLE_MODE) begin : g_nibble
        assign sel_n = nibble_write_sel_n;
    end else begin : g_byte
        assign sel_n = byte_lane_write_sel_n[SEL_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Write beats: first word at the next positive edge, second at
    // the negative edge after it
    logic wr_pend_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic wr_b1_q;
    logic [ADDR_W-1:0] wr_b1_addr_q;

    // Address held per beat so a new command cannot disturb it
    always_ff @(posedge k_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            wr_b1_q <= 1'b0;
            wr_b1_addr_q <= '0;
        end else begin
            wr_pend_q <= cmd_wr;
            wr_addr_q <= addr;
            wr_b1_q <= wr_pend_q;
            wr_b1_addr_q <= wr_addr_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read pipeline, one stage per positive clock cycle of latency
    logic [RD_LAT-1:0] rd_vld_q;
    logic [RD_LAT-1:0][ADDR_W-1:0] rd_addr_q;
    logic [RD_LAT-1:0] rd_vld_d;
    logic [RD_LAT-1:0][ADDR_W-1:0] rd_addr_d;

    assign rd_vld_d[0] = cmd_rd;
    assign rd_addr_d[0] = addr;
    for (genvar s = 1; s < RD_LAT; s++) begin : g_rd_stage
        assign rd_vld_d[s] = rd_vld_q[s-1];
        assign rd_addr_d[s] = rd_addr_q[s-1];
    end

    always_ff @(posedge k_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            rd_vld_q <= '0;
            rd_addr_q <= '0;
        end else begin
            rd_vld_q <= rd_vld_d;
            rd_addr_q <= rd_addr_d;
        end
    end

    // DLL-off timing taps the pipeline earlier
    wire logic tap_vld = dll_off ? rd_vld_q[DLL_OFF_RD_LAT-1] :
                                   rd_vld_q[RD_LAT-1];
    wire logic [ADDR_W-1:0] tap_addr = dll_off ?
        rd_addr_q[DLL_OFF_RD_LAT-1] : rd_addr_q[RD_LAT-1];

    ////////////////////////////////////////////////////////////////////
    // Storage: two arrays, one per beat
    logic [DATA_W-1:0] rdata0;
    logic [DATA_W-1:0] rdata1;
    logic rd_b1_pend_q;
    logic [ADDR_W-1:0] rd_b1_addr_q;

    burst_storage #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W),
        .LANE_W(LANE_W),
        .SEL_W(SEL_W)
    ) u_store (
        .k_clk(k_clk),
        .kn_clk(kn_clk),
        .rst_n(k_rst_n),
        .we0(wr_pend_q),
        .we1(wr_b1_q),
        .waddr0(wr_addr_q),
        .waddr1(wr_b1_addr_q),
        .wdata(dq_i),
        .wsel_n(sel_n),
        .raddr0(tap_addr),
        .raddr1(rd_b1_addr_q),
        .rdata0(rdata0),
        .rdata1(rdata1)
    );

    ////////////////////////////////////////////////////////////////////
    // First read beat and echo phase, positive clock
    logic [DATA_W-1:0] q0_q;
    logic oe_p_q;
    logic echo_p_q;

    always_ff @(posedge k_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            q0_q <= '0;
            oe_p_q <= 1'b0;
            rd_b1_pend_q <= 1'b0;
            rd_b1_addr_q <= '0;
            echo_p_q <= 1'b0;
        end else begin
            q0_q <= rdata0;
            oe_p_q <= tap_vld;
            rd_b1_pend_q <= tap_vld;
            rd_b1_addr_q <= tap_addr;
            echo_p_q <= !echo_p_q;
        end
    end

    // Second read beat and echo phase, negative clock
    logic [DATA_W-1:0] q1_q;
    logic oe_n_q;
    logic echo_n_q;

    always_ff @(posedge kn_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            q1_q <= '0;
            oe_n_q <= 1'b0;
            echo_n_q <= 1'b0;
        end else begin
            q1_q <= rdata1;
            oe_n_q <= rd_b1_pend_q;
            echo_n_q <= !echo_n_q;
        end
    end

    // Data, enable and valid pins follow the clock phase, each half from its own flop; echo_timing_out is the XOR of both echo flops, echo_timing_out_n its complement
    assign dq_o = k_clk ? q0_q : q1_q;
    assign dq_oe = k_clk ? oe_p_q : oe_n_q;
    assign output_valid_flag = k_clk ? oe_p_q : oe_n_q;
    assign echo_timing_out = echo_p_q ^ echo_n_q;
    assign echo_timing_out_n = !(echo_p_q ^ echo_n_q);

    ////////////////////////////////////////////////////////////////////
    // Access toggles, crossed to the core clock
    acc_evt_t evt_tog_q;

    always_ff @(posedge k_clk or negedge k_rst_n) begin
        if (!k_rst_n) begin
            evt_tog_q <= '0;
        end else begin
            evt_tog_q.rd <= evt_tog_q.rd ^ cmd_rd;
            evt_tog_q.wr <= evt_tog_q.wr ^ cmd_wr;
        end
    end

    logic [`SRAM_EVT_W-1:0] evt_lvl;
    for (genvar b = 0; b < `SRAM_EVT_W; b++) begin : g_evt_sync
        pin_sync3 #(.RESET_VAL(1'b0)) u_evt (
            .clk(mclk),
            .rst_n(rstn),
            .pin(evt_tog_q[b]),
            .level(evt_lvl[b])
        );
    end

    logic dll_on_m;
    pin_sync3 #(.RESET_VAL(1'b1)) u_dll_m (
        .clk(mclk),
        .rst_n(rstn),
        .pin(dll_disable_n),
        .level(dll_on_m)
    );

    // One core-clock pulse per accepted command
    acc_evt_t evt_prev_q;
    wire acc_evt_t evt_lvl_s = acc_evt_t'(evt_lvl);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            evt_prev_q <= '0;
            rd_event <= 1'b0;
            wr_event <= 1'b0;
            dll_off_status <= 1'b0;
        end else begin
            evt_prev_q <= evt_lvl_s;
            rd_event <= evt_lvl_s.rd ^ evt_prev_q.rd;
            wr_event <= evt_lvl_s.wr ^ evt_prev_q.wr;
            dll_off_status <= !dll_on_m;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks on the link side
    sequence s_rd_norm;
        cmd_rd && !dll_off;
    endsequence

    sequence s_rd_short;
        cmd_rd && dll_off;
    endsequence

    a_rd_first_beat: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        s_rd_norm |=> ##RD_LAT_A oe_p_q)
    else $error("first read beat not driven at latency");

    a_dll_off_lat: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        s_rd_short |=> ##DLL_LAT_A oe_p_q)
    else $error("short latency read beat missing");

    a_rd_release: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        (!cmd_rd) [*4] |-> !oe_p_q)
    else $error("bus driven without a read");

    a_rd_addr_take: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        cmd_rd |=> rd_vld_q[0] && rd_addr_q[0] == $past(addr))
    else $error("read address not captured");

    a_wr_two_beats: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        cmd_wr |=> wr_pend_q && wr_addr_q == $past(addr) ##1
            wr_b1_q && wr_b1_addr_q == $past(wr_addr_q))
    else $error("write did not give two beats");

    a_no_strobe_idle: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        load_strobe_n |=> !wr_pend_q && !rd_vld_q[0])
    else $error("access started without the load strobe");

    a_echo_runs: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        k_rst_n |=> echo_p_q != $past(echo_p_q))
    else $error("echo phase stalled");

    a_rd_second_beat: assert property (
        @(posedge kn_clk) disable iff (!k_rst_n)
        rd_b1_pend_q |=> oe_n_q)
    else $error("second read beat not valid");

endmodule
`default_nettype wire

// File: tb/sram_ctrl_model.sv
// Behavioural memory controller facing the burst SRAM port
`default_nettype none
module sram_ctrl_model #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 10,
    parameter int SEL_W = 4
) (
    input wire logic k_clk,
    output logic load_strobe_n,
    output logic rw_dir,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] dq_drv,
    output logic [SEL_W-1:0] sel_n
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic rd;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] w0;
        logic [DATA_W-1:0] w1;
        logic [SEL_W-1:0] s0;
        logic [SEL_W-1:0] s1;
    } ctrl_cmd_t;
    ctrl_cmd_t cmd_q[$];
    ctrl_cmd_t cur;
    ctrl_cmd_t w_next;
    ctrl_cmd_t w_now;
    logic w0_due = 1'b0;
    logic w1_due = 1'b0;

    initial begin
        load_strobe_n = 1'b1;
        rw_dir = 1'b0;
        addr = '0;
        dq_drv = '0;
        sel_n = '1;
    end

    // Queue one command; queued commands go out back to back
    task automatic issue(input logic rd, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] w0, input logic [DATA_W-1:0] w1,
            input logic [SEL_W-1:0] s0, input logic [SEL_W-1:0] s1);
        cmd_q.push_back({rd, a, w0, w1, s0, s1});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Commands and first beats change at the falling edge, never sampled
    always @(negedge k_clk) begin
        if (w0_due) begin
            dq_drv <= w_next.w0;
            sel_n <= w_next.s0;
        end else begin
            dq_drv <= ~dq_drv; // Released bus never keeps old data
            sel_n <= ~sel_n;
        end
        w_now <= w_next;
        w1_due <= w0_due;
        if (cmd_q.size() > 0) begin
            cur = cmd_q.pop_front();
            load_strobe_n <= 1'b0;
            rw_dir <= cur.rd;
            addr <= cur.a;
            w_next <= cur;
            w0_due <= ~cur.rd;
        end else begin
            load_strobe_n <= 1'b1;
            rw_dir <= ~rw_dir; // Idle lines wander to catch stray use
            addr <= ~addr;
            w0_due <= 1'b0;
        end
    end

    // Second beat goes out just after the first is taken
    always @(posedge k_clk) begin
        if (w1_due) begin
            dq_drv <= w_now.w1;
            sel_n <= w_now.s1;
        end else begin
            dq_drv <= ~dq_drv;
        end
    end
endmodule
`default_nettype wire

// File: tb/ddr_burst2_sram_port_test.sv
// Self-checking bench for the two-word burst SRAM port
`default_nettype none
module ddr_burst2_sram_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DW = 36;
    localparam int AW = 10;
    localparam int LANES = DW / 9;
    localparam int RD_LAT_T = 2;
    localparam int OFF_LAT_T = 1;
    typedef struct packed {
        logic [DW-1:0] w0;
        logic [DW-1:0] w1;
    } rd_note_t;

    logic mclk = 1'b0;
    logic k_clk = 1'b0;
    logic rstn = 1'b0;
    logic dll_disable_n = 1'b1;
    logic started = 1'b0;
    logic echo_hi;
    wire logic kn_clk;
    wire logic [DW-1:0] dq_i;
    logic load_strobe_n, rw_dir, dq_oe, output_valid_flag;
    logic echo_timing_out, echo_timing_out_n, rd_event, wr_event;
    logic dll_off_status;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq_drv, dq_o;
    logic [LANES-1:0] sel_n;
    logic [DW-1:0] mem_e [2**AW];
    logic [DW-1:0] mem_o [2**AW];
    rd_note_t exp_q[$];
    rd_note_t note;
    int due_q[$];
    int err_count = 0;
    int n_tests = 0;
    int kcyc = 0;
    int n_rd_cmd = 0, n_wr_cmd = 0, n_rd_ev = 0, n_wr_ev = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clocks; the link clock is offset so the two never line up
    always #2.5 mclk = ~mclk;
    initial begin
        #7.3;
        forever #32 k_clk = ~k_clk;
    end
    assign kn_clk = ~k_clk;
    // Input side sees the controller only: a read's release and a write
    // beat's sample share one edge, which a bus mux here cannot order
    assign dq_i = dq_drv;

    sram_ctrl_model #(.DATA_W(DW), .ADDR_W(AW), .SEL_W(LANES))
        u_sram_ctrl_model (.k_clk(k_clk), .load_strobe_n(load_strobe_n),
        .rw_dir(rw_dir), .addr(addr), .dq_drv(dq_drv), .sel_n(sel_n));

    ddr_burst2_sram_port #(.DATA_W(DW), .ADDR_W(AW), .RD_LAT(RD_LAT_T),
        .DLL_OFF_RD_LAT(OFF_LAT_T), .BYTE_SEL_W(LANES))
        u_ddr_burst2_sram_port (.mclk(mclk), .rstn(rstn), .k_clk(k_clk),
        .kn_clk(kn_clk), .load_strobe_n(load_strobe_n), .rw_dir(rw_dir),
        .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
        .nibble_write_sel_n(sel_n[1:0]), .byte_lane_write_sel_n(sel_n),
        .dll_disable_n(dll_disable_n), .output_valid_flag(output_valid_flag),
        .echo_timing_out(echo_timing_out),
        .echo_timing_out_n(echo_timing_out_n), .rd_event(rd_event),
        .wr_event(wr_event), .dll_off_status(dll_off_status));

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [DW-1:0] exp,
            input logic [DW-1:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Lane-masked update of the reference copy
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
            input logic [DW-1:0] nw, input logic [LANES-1:0] s);
        logic [DW-1:0] r;
        r = old;
        for (int l = 0; l < LANES; l++)
            if (!s[l]) r[9*l +: 9] = nw[9*l +: 9];
        return r;
    endfunction

    task automatic wr(input logic [AW-1:0] a, input logic [LANES-1:0] s0,
            input logic [LANES-1:0] s1);
        logic [DW-1:0] w0;
        logic [DW-1:0] w1;
        w0 = DW'({$urandom(), $urandom()});
        w1 = DW'({$urandom(), $urandom()});
        mem_e[a] = merge(mem_e[a], w0, s0);
        mem_o[a] = merge(mem_o[a], w1, s1);
        u_sram_ctrl_model.issue(1'b0, a, w0, w1, s0, s1);
    endtask

    task automatic rd(input logic [AW-1:0] a);
        exp_q.push_back({mem_e[a], mem_o[a]});
        u_sram_ctrl_model.issue(1'b1, a, '0, '0, '0, '0);
    endtask

    // Bounded wait until every queued command and read has come through
    task automatic drain();
        int i;
        for (i = 0; i < 300; i++) begin
            if (u_sram_ctrl_model.cmd_q.size() == 0 && exp_q.size() == 0)
                break;
            @(posedge k_clk);
        end
        if (i == 300) begin
            err_count++;
            $display("[ERR] drain expected idle seen busy");
            finish_test();
        end
        repeat (4) @(posedge k_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watch the bus: each valid window takes the oldest note
    initial forever begin
        @(posedge k_clk);
        kcyc++;
        if (rstn && !load_strobe_n) begin
            if (rw_dir) begin
                n_rd_cmd++;
                due_q.push_back(kcyc + (dll_disable_n ? RD_LAT_T : OFF_LAT_T));
            end else begin
                n_wr_cmd++;
            end
        end
        #16;
        if (output_valid_flag === 1'b1 && exp_q.size() > 0 &&
                due_q.size() > 0) begin
            note = exp_q.pop_front();
            chk("latency", DW'(due_q.pop_front()), DW'(kcyc));
            chk("beat0", note.w0, dq_o);
            chk("oe_b0", DW'(1), DW'(dq_oe));
            @(negedge k_clk);
            #16;
            chk("valid_b1", DW'(1), DW'(output_valid_flag));
            chk("beat1", note.w1, dq_o);
        end else begin
            chk("valid_idle", '0, DW'(output_valid_flag));
            chk("oe_idle", '0, DW'(dq_oe));
        end
    end

    // Echo clock flips every half period once the link runs
    initial forever begin
        @(posedge k_clk);
        #16;
        echo_hi = echo_timing_out;
        @(negedge k_clk);
        #16;
        if (started) begin
            chk("echo", DW'(!echo_hi), DW'(echo_timing_out));
            chk("echo_n", DW'(!echo_timing_out), DW'(echo_timing_out_n));
        end
    end

    // Count the core-side pulses, one per accepted command
    always @(posedge mclk) begin
        if (rd_event === 1'b1) n_rd_ev++;
        if (wr_event === 1'b1) n_wr_ev++;
    end

    initial begin
        #100us;
        err_count++;
        $display("[ERR] run expected done seen hang");
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h841a));
        // Long enough for the link side to see three clock periods
        repeat (40) @(negedge mclk);
        chk("rst_oe", '0, DW'(dq_oe));
        chk("rst_events", '0, DW'({rd_event, wr_event, dll_off_status}));
        rstn = 1'b1;
        repeat (6) @(posedge k_clk);
        started = 1'b1;
        // Full writes, back to back, including the top address
        for (int a = 0; a < 16; a++) wr(AW'(a), '0, '0);
        wr({AW{1'b1}}, '0, '0);
        drain();
        // Masked writes mixed with reads of other addresses
        for (int i = 0; i < 24; i++) begin
            if ($urandom_range(1) == 1)
                wr(AW'(i % 8), LANES'($urandom()), LANES'($urandom()));
            else
                rd(AW'(8 + $urandom_range(7)));
        end
        drain();
        for (int a = 0; a < 8; a++) rd(AW'(a));
        rd({AW{1'b1}});
        drain();
        // Short-latency timing with the strap low
        @(negedge mclk);
        dll_disable_n = 1'b0;
        repeat (8) @(posedge k_clk);
        chk("dll_off", DW'(1), DW'(dll_off_status));
        for (int a = 0; a < 4; a++) rd(AW'(a));
        wr(AW'(5), 4'h5, 4'ha);
        rd(AW'(9));
        rd(AW'(5));
        wr(AW'(6), '1, '1);
        rd(AW'(6));
        drain();
        @(negedge mclk);
        dll_disable_n = 1'b1;
        repeat (8) @(posedge k_clk);
        chk("dll_on", '0, DW'(dll_off_status));
        rd(AW'(5));
        drain();
        repeat (20) @(posedge mclk);
        chk("rd_events", DW'(n_rd_cmd), DW'(n_rd_ev));
        chk("wr_events", DW'(n_wr_cmd), DW'(n_wr_ev));
        finish_test();
    end
endmodule
`default_nettype wire
